// File: hdl/gpio_slice_pkg.sv
// shared constants for the parallel gpio bank slice
package gpio_slice_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned PIN_W  = 32;
  localparam int unsigned BANK_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // register indices; the byte address is four times the index
  localparam logic [15:0] IDX_PIN_LEVEL_LOW_BANK     = 16'h4402;
  localparam logic [15:0] IDX_PIN_SELECT_MID_BANK    = 16'h4403;
  localparam logic [15:0] IDX_PIN_DIRECTION_MID_BANK = 16'h4404;
  localparam logic [15:0] IDX_PIN_LEVEL_MID_BANK     = 16'h4405;

  function automatic logic [ADDR_W-1:0] reg_addr(input logic [15:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction : reg_addr

  localparam logic [ADDR_W-1:0] ADDR_PIN_LEVEL_LOW_BANK     = reg_addr(IDX_PIN_LEVEL_LOW_BANK);
  localparam logic [ADDR_W-1:0] ADDR_PIN_SELECT_MID_BANK    = reg_addr(IDX_PIN_SELECT_MID_BANK);
  localparam logic [ADDR_W-1:0] ADDR_PIN_DIRECTION_MID_BANK = reg_addr(IDX_PIN_DIRECTION_MID_BANK);
  localparam logic [ADDR_W-1:0] ADDR_PIN_LEVEL_MID_BANK     = reg_addr(IDX_PIN_LEVEL_MID_BANK);

  ////////////////////////////////////////////////////////////////////////////
  // field positions: bit n of a bank register is pin (base + n)
  localparam int unsigned LOW_BANK_BASE_PIN = 0;
  localparam int unsigned MID_BANK_BASE_PIN = 16;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [BANK_W-1:0] RESET_PIN_SELECT    = 16'h0000;
  localparam logic [BANK_W-1:0] RESET_PIN_DIRECTION = 16'h0000;
  localparam logic [DATA_W-1:0] READ_IDLE_VALUE     = 16'h0000;
  localparam logic [PIN_W-1:0]  PINS_RELEASED       = 32'h0000_0000;

endpackage : gpio_slice_pkg

// File: hdl/parallel_gpio_bank_slice.sv
// data register for pins 0-15 and select, direction and data registers for pins 16-31
module parallel_gpio_bank_slice (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [19:0] i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr_strobe,
  input  wire logic        i_rd_strobe,
  output logic      [15:0] o_rdata,
  input  wire logic [31:0] i_pin,
  output logic      [31:0] o_pin,
  output logic      [31:0] o_pin_oe,
  input  wire logic [15:0] i_low_select,
  input  wire logic [15:0] i_low_direction,
  input  wire logic        i_bus_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [31:0] pin_level;

  logic [15:0] select_mid_reg;
  logic [15:0] select_mid_next;
  logic [15:0] direction_mid_reg;
  logic [15:0] direction_mid_next;
  logic [15:0] level_low_reg;
  logic [15:0] level_low_next;
  logic [15:0] level_mid_reg;
  logic [15:0] level_mid_next;

  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic [31:0] pin_out_reg;
  logic [31:0] pin_out_next;
  logic [31:0] pin_oe_reg;
  logic [31:0] pin_oe_next;

  logic [31:0] select_all;
  logic [31:0] direction_all;
  logic [31:0] level_all;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // per bit: stored value for outputs, live pin for inputs
  function automatic logic [15:0] read_level(input logic [15:0] dir,
                                             input logic [15:0] stored,
                                             input logic [15:0] live);
    return (dir & stored) | (~dir & live);
  endfunction : read_level

  // a pin drives only when selected and set as output
  function automatic logic [15:0] drive_enable(input logic [15:0] sel,
                                               input logic [15:0] dir);
    return sel & dir;
  endfunction : drive_enable

  // only the four slice addresses decode; anything else is refused
  function automatic logic is_mapped(input logic [19:0] addr);
    return (addr == gpio_slice_pkg::ADDR_PIN_LEVEL_LOW_BANK) ||
           (addr == gpio_slice_pkg::ADDR_PIN_SELECT_MID_BANK) ||
           (addr == gpio_slice_pkg::ADDR_PIN_DIRECTION_MID_BANK) ||
           (addr == gpio_slice_pkg::ADDR_PIN_LEVEL_MID_BANK);
  endfunction : is_mapped

  ////////////////////////////////////////////////////////////////////////////
  // pin input synchroniser

  pin_level_sync u_pin_level_sync (
    .i_clk   (i_clk),
    .i_pin   (i_pin),
    .o_level (pin_level)
  );

  assign select_all    = {select_mid_reg, i_low_select};
  assign direction_all = {direction_mid_reg, i_low_direction};
  assign level_all     = {level_mid_reg, level_low_reg};

  ////////////////////////////////////////////////////////////////////////////
  // register file and pin drive, next state

  always_comb begin
    select_mid_next    = select_mid_reg;
    direction_mid_next = direction_mid_reg;
    level_low_next     = level_low_reg;
    level_mid_next     = level_mid_reg;
    rdata_next         = gpio_slice_pkg::READ_IDLE_VALUE;
    pin_out_next       = gpio_slice_pkg::PINS_RELEASED;
    pin_oe_next        = gpio_slice_pkg::PINS_RELEASED;

    if (!i_rst_n) begin
      select_mid_next    = gpio_slice_pkg::RESET_PIN_SELECT;
      direction_mid_next = gpio_slice_pkg::RESET_PIN_DIRECTION;
      // sampled every reset cycle, so the last one before release wins
      level_low_next     = pin_level[15:0];
      level_mid_next     = pin_level[31:16];
    end else begin
      if (i_wr_strobe) begin
        unique case (i_addr)
          gpio_slice_pkg::ADDR_PIN_LEVEL_LOW_BANK: begin
            level_low_next = i_wdata;
          end
          gpio_slice_pkg::ADDR_PIN_SELECT_MID_BANK: begin
            select_mid_next = i_wdata;
          end
          gpio_slice_pkg::ADDR_PIN_DIRECTION_MID_BANK: begin
            direction_mid_next = i_wdata;
          end
          gpio_slice_pkg::ADDR_PIN_LEVEL_MID_BANK: begin
            level_mid_next = i_wdata;
          end
          default: begin
            // unmapped writes are dropped
          end
        endcase
      end

      if (i_rd_strobe) begin
        unique case (i_addr)
          gpio_slice_pkg::ADDR_PIN_LEVEL_LOW_BANK: begin
            rdata_next = read_level(i_low_direction, level_low_reg, pin_level[15:0]);
          end
          gpio_slice_pkg::ADDR_PIN_SELECT_MID_BANK: begin
            rdata_next = select_mid_reg;
          end
          gpio_slice_pkg::ADDR_PIN_DIRECTION_MID_BANK: begin
            rdata_next = direction_mid_reg;
          end
          gpio_slice_pkg::ADDR_PIN_LEVEL_MID_BANK: begin
            rdata_next = read_level(direction_mid_reg, level_mid_reg, pin_level[31:16]);
          end
          default: begin
            rdata_next = gpio_slice_pkg::READ_IDLE_VALUE;
          end
        endcase
      end

      // bus ownership beats any gpio select bit
      if (!i_bus_mode) begin
        pin_oe_next = {drive_enable(select_mid_reg, direction_mid_reg),
                       drive_enable(i_low_select, i_low_direction)};
        // the value is presented even while released; only oe gates it
        pin_out_next = level_all;
      end else begin
        pin_out_next = level_all;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge i_clk) begin
    select_mid_reg    <= select_mid_next;
    direction_mid_reg <= direction_mid_next;
    level_low_reg     <= level_low_next;
    level_mid_reg     <= level_mid_next;
    rdata_reg         <= rdata_next;
    pin_out_reg       <= pin_out_next;
    pin_oe_reg        <= pin_oe_next;
  end

  assign o_rdata  = rdata_reg;
  assign o_pin    = pin_out_reg;
  assign o_pin_oe = pin_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_clk);
  endclocking

  default disable iff (!i_rst_n);

  logic past_valid_reg;

  always_ff @(posedge i_clk) begin
    past_valid_reg <= i_rst_n;
  end

  chk_read_input_live: assert property (
    (i_rd_strobe && i_addr == gpio_slice_pkg::ADDR_PIN_LEVEL_MID_BANK)
    |=> (((o_rdata ^ $past(pin_level[31:16])) & ~$past(direction_mid_reg)) == 16'h0000)
  ) else $error("input pin read does not show the pin level");

  chk_read_low_live: assert property (
    (i_rd_strobe && i_addr == gpio_slice_pkg::ADDR_PIN_LEVEL_LOW_BANK)
    |=> (((o_rdata ^ $past(pin_level[15:0])) & ~$past(i_low_direction)) == 16'h0000)
  ) else $error("low bank input read does not show the pin level");

  chk_drive_level_follows: assert property (
    (past_valid_reg && !i_bus_mode)
    |=> (((o_pin ^ $past(level_all)) & o_pin_oe) == 32'h0000_0000)
  ) else $error("driven pin level differs from stored data");

  chk_unselected_released: assert property (
    past_valid_reg |-> ((o_pin_oe & ~$past(select_all)) == 32'h0000_0000)
  ) else $error("unselected pin is driven");

  chk_selected_output_drives: assert property (
    (past_valid_reg && !$past(i_bus_mode))
    |-> (($past(select_all & direction_all) & ~o_pin_oe) == 32'h0000_0000)
  ) else $error("selected output pin is not driven");

  chk_input_never_drives: assert property (
    past_valid_reg |-> ((o_pin_oe & ~$past(direction_all)) == 32'h0000_0000)
  ) else $error("input pin is driven");

  chk_reset_clears_config: assert property (
    (!past_valid_reg) |-> (select_mid_reg == 16'h0000 && direction_mid_reg == 16'h0000 && o_pin_oe == 32'h0)
  ) else $error("configuration not cleared by reset");

  chk_reset_captures_pins: assert property (
    (!past_valid_reg) |-> (level_all == $past(pin_level))
  ) else $error("data register did not capture pin level at reset");

  chk_write_maps_bits: assert property (
    (i_wr_strobe && i_addr == gpio_slice_pkg::ADDR_PIN_LEVEL_MID_BANK)
    |=> ##1 (o_pin[31:16] == $past(i_wdata, 2))
  ) else $error("mid bank data bits not mapped to pins 16-31");

  chk_bus_mode_wins: assert property (
    i_bus_mode |=> (o_pin_oe == 32'h0000_0000)
  ) else $error("gpio drives a pin owned by the external bus");

  chk_read_one_cycle: assert property (
    (!i_rd_strobe) |=> (o_rdata == 16'h0000)
  ) else $error("read data present without a read strobe");

  chk_read_mid_stored: assert property (
    (i_rd_strobe && i_addr == gpio_slice_pkg::ADDR_PIN_LEVEL_MID_BANK)
    |=> (((o_rdata ^ $past(level_mid_reg)) & $past(direction_mid_reg)) == 16'h0000)
  ) else $error("output pin read does not show the stored bit");

  chk_read_low_stored: assert property (
    (i_rd_strobe && i_addr == gpio_slice_pkg::ADDR_PIN_LEVEL_LOW_BANK)
    |=> (((o_rdata ^ $past(level_low_reg)) & $past(i_low_direction)) == 16'h0000)
  ) else $error("low bank output read does not show the stored bit");

  chk_select_readback: assert property (
    (i_rd_strobe && i_addr == gpio_slice_pkg::ADDR_PIN_SELECT_MID_BANK)
    |=> (o_rdata == $past(select_mid_reg))
  ) else $error("select register does not read back");

  chk_direction_readback: assert property (
    (i_rd_strobe && i_addr == gpio_slice_pkg::ADDR_PIN_DIRECTION_MID_BANK)
    |=> (o_rdata == $past(direction_mid_reg))
  ) else $error("direction register does not read back");

  chk_select_write_lands: assert property (
    (i_wr_strobe && i_addr == gpio_slice_pkg::ADDR_PIN_SELECT_MID_BANK)
    |=> (select_mid_reg == $past(i_wdata))
  ) else $error("select write did not land");

  chk_direction_write_lands: assert property (
    (i_wr_strobe && i_addr == gpio_slice_pkg::ADDR_PIN_DIRECTION_MID_BANK)
    |=> (direction_mid_reg == $past(i_wdata))
  ) else $error("direction write did not land");

  chk_low_write_maps: assert property (
    (i_wr_strobe && i_addr == gpio_slice_pkg::ADDR_PIN_LEVEL_LOW_BANK)
    |=> ##1 (o_pin[15:0] == $past(i_wdata, 2))
  ) else $error("low bank data bits not mapped to pins 0-15");

  // a stray write must not disturb any pin setting
  chk_unmapped_write_dropped: assert property (
    (i_wr_strobe && !is_mapped(i_addr))
    |=> ($stable(select_mid_reg) && $stable(direction_mid_reg) && $stable(level_all))
  ) else $error("write to an unmapped address changed a register");

  chk_unmapped_read_zero: assert property (
    (i_rd_strobe && !is_mapped(i_addr)) |=> (o_rdata == 16'h0000)
  ) else $error("read of an unmapped address returned data");

  cov_output_drive: cover property (
    (i_wr_strobe && i_addr == gpio_slice_pkg::ADDR_PIN_DIRECTION_MID_BANK && i_wdata != 16'h0000)
    ##[1:20] (o_pin_oe[31:16] != 16'h0000)
  );

  cov_input_read: cover property (
    (i_rd_strobe && i_addr == gpio_slice_pkg::ADDR_PIN_LEVEL_MID_BANK && direction_mid_reg == 16'h0000)
    ##1 (o_rdata != 16'h0000)
  );

  cov_bus_takeover: cover property (
    (o_pin_oe != 32'h0000_0000) ##1 i_bus_mode ##1 (o_pin_oe == 32'h0000_0000)
  );

  cov_low_output_drive: cover property (
    ((i_low_select & i_low_direction) != 16'h0000) ##2 (o_pin_oe[15:0] != 16'h0000)
  );

  cov_unmapped_read: cover property (
    (i_rd_strobe && !is_mapped(i_addr)) ##1 (o_rdata == 16'h0000)
  );

endmodule : parallel_gpio_bank_slice

// File: hdl/pin_level_sync.sv
// two-flop synchroniser for the 32 pin inputs
module pin_level_sync (
  input  wire logic        i_clk,
  input  wire logic [31:0] i_pin,
  output logic      [31:0] o_level
);

  logic [31:0] stage1_reg;
  logic [31:0] stage2_reg;

  // no reset here: the data register must see the real pin level during reset
  always_ff @(posedge i_clk) begin
    stage1_reg <= i_pin;
    stage2_reg <= stage1_reg;
  end

  assign o_level = stage2_reg;

endmodule : pin_level_sync

// File: tb/parallel_gpio_bank_slice_bench.sv
// self-checking bench for the gpio bank slice
module parallel_gpio_bank_slice_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [19:0] A_LOW = gpio_slice_pkg::ADDR_PIN_LEVEL_LOW_BANK;
  localparam logic [19:0] A_SEL = gpio_slice_pkg::ADDR_PIN_SELECT_MID_BANK;
  localparam logic [19:0] A_DIR = gpio_slice_pkg::ADDR_PIN_DIRECTION_MID_BANK;
  localparam logic [19:0] A_MID = gpio_slice_pkg::ADDR_PIN_LEVEL_MID_BANK;
  logic        i_clk, i_rst_n, i_wr_strobe, i_rd_strobe, i_bus_mode, rd_q;
  logic [19:0] i_addr;
  logic [15:0] i_wdata, i_low_select, i_low_direction, o_rdata, d, p;
  logic [31:0] o_pin, o_pin_oe, pin_wire, ext;
  logic [15:0] exp_q[$];
  int          errors, n_tests, cycles, seed;

  parallel_gpio_bank_slice DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr_strobe(i_wr_strobe), .i_rd_strobe(i_rd_strobe), .o_rdata(o_rdata), .i_pin(pin_wire),
    .o_pin(o_pin), .o_pin_oe(o_pin_oe), .i_low_select(i_low_select),
    .i_low_direction(i_low_direction), .i_bus_mode(i_bus_mode));
  pin_wire_model pins (.i_pin_out(o_pin), .i_pin_oe(o_pin_oe), .i_ext_level(ext), .o_wire(pin_wire));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  // ceiling well above the hundred or so cycles the sequence needs
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      test_done();
    end
  end

  task automatic chk(string name, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  ////////////////////////////////////////////////////////////////////////////
  // read data stand only in the cycle after the strobe, so look there
  always @(posedge i_clk) rd_q <= i_rd_strobe;
  always @(negedge i_clk) if (rd_q === 1'b1) chk("o_rdata", exp_q.pop_front(), o_rdata);

  task automatic wr(logic [19:0] a, logic [15:0] v);
    @(posedge i_clk);
    i_wr_strobe <= 1'b1;
    i_addr      <= a;
    i_wdata     <= v;
    @(posedge i_clk);
    i_wr_strobe <= 1'b0;
  endtask : wr

  task automatic rd(logic [19:0] a, logic [15:0] e);
    @(posedge i_clk);
    i_rd_strobe <= 1'b1;
    i_addr      <= a;
    exp_q.push_back(e);
    @(posedge i_clk);
    i_rd_strobe <= 1'b0;
  endtask : rd

  // three edges through the registers and pins, then settled
  task automatic settle();
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 56887;
    {i_rst_n, i_wr_strobe, i_rd_strobe, i_bus_mode} = 4'h0;
    {i_addr, i_wdata, i_low_select, i_low_direction} = 68'h0;
    {errors, n_tests, cycles} = 96'h0;
    ext = $random(seed);
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    settle();
    chk("oe after reset", 32'h0, o_pin_oe);
    rd(A_LOW, ext[15:0]);
    rd(A_MID, ext[31:16]);
    rd(A_SEL, 16'h0000);
    rd(A_DIR, 16'h0000);
    rd(20'h11018, 16'h0000);
    // outputs but unselected: the stored reset value shows without driving
    wr(A_DIR, 16'hffff);
    i_low_direction <= 16'hffff;
    rd(A_MID, ext[31:16]);
    rd(A_LOW, ext[15:0]);
    i_low_direction <= 16'h0000;
    wr(A_DIR, 16'h0000);
    $display("test reset_values done");

    d = 16'($random(seed));
    p = 16'($random(seed));
    wr(A_MID, d);
    wr(A_SEL, 16'hffff);
    wr(A_DIR, p);
    wr(20'h11011, 16'hffff);
    settle();
    chk("oe mid", {p, 16'h0}, o_pin_oe);
    chk("pin mid", {d & p, 16'h0}, {o_pin[31:16] & p, 16'h0});
    rd(A_MID, (d & p) | (ext[31:16] & ~p));
    rd(A_SEL, 16'hffff);
    rd(A_DIR, p);
    ext <= $random(seed);
    settle();
    rd(A_MID, (d & p) | (ext[31:16] & ~p));
    $display("test mid_bank done");

    @(posedge i_clk);
    i_low_select    <= 16'hffff;
    i_low_direction <= p;
    wr(A_LOW, d);
    settle();
    chk("oe low", {p, p}, o_pin_oe);
    chk("pin low", {16'h0, d & p}, {16'h0, o_pin[15:0] & p});
    rd(A_LOW, (d & p) | (ext[15:0] & ~p));
    $display("test low_bank done");

    @(posedge i_clk);
    i_bus_mode <= 1'b1;
    settle();
    chk("oe bus mode", 32'h0, o_pin_oe);
    @(posedge i_clk);
    i_bus_mode <= 1'b0;
    settle();
    chk("oe gpio mode", {p, p}, o_pin_oe);
    wr(A_SEL, 16'h0000);
    settle();
    chk("oe deselected", {16'h0, p}, o_pin_oe);
    $display("test release done");

    // reset in mid-run: mid-bank config clears, low-bank pins are released during reset and driven again after it, data registers take the new pin levels
    @(posedge i_clk);
    ext     <= $random(seed);
    i_rst_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    settle();
    chk("oe after mid reset", {16'h0, p}, o_pin_oe);
    rd(A_DIR, 16'h0000);
    rd(A_LOW, ext[15:0]);
    rd(A_MID, ext[31:16]);
    wr(A_DIR, 16'hffff);
    rd(A_MID, ext[31:16]);
    settle();
    chk("reads answered", 32'h0, exp_q.size());
    $display("test mid_reset done");
    test_done();
  end
endmodule : parallel_gpio_bank_slice_bench

// File: tb/pin_wire_model.sv
// external pin model: wire level seen by the slice's pin inputs
module pin_wire_model (
  input  wire logic [31:0] i_pin_out,
  input  wire logic [31:0] i_pin_oe,
  input  wire logic [31:0] i_ext_level,
  output logic      [31:0] o_wire
);
  timeunit 1ns;
  timeprecision 1ns;
  // a driven pin wins; a released pin shows the outside device, which holds its level
  assign o_wire = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_level);
endmodule : pin_wire_model
